//--- lass_pkg.sv
// lass_pkg: shared constants for the linear array scan sequencer and its controller
// assumes: both ends run on one 20 MHz clock; the link is start, clock and analog out
//
// Summary of operation
// - only start input and clock steer device
// - 132-position shift register plus integrator reset logic
// - start sampled high at clock edge begins scan
// - all pixels held at one common instant
// - order: dummy, dummy, 128 pixels, dummy, dark
// - integrators reset until falling edge of pulse 18
// - integration at least 115 periods plus 10 us
// - start returns low before the next rising edge
// - first scan after power-up discarded, priming only
// - keep integration at most 2 ms when hot; lass_ctrl only raises int_overrun_out when starts lie over 2 ms apart
// - full readout takes 133 clock pulses
// - integration runs pulse 18 to next start
// - output high impedance after 132 values shown
// - two dummies, 128 pixels, one dummy, dark level, one per clock
package lass_pkg;

    // ------------------------------------------------------------
    // array geometry and scan timing
    // ------------------------------------------------------------
    localparam int          LASS_PIXELS       = 128;
    localparam int          LASS_POSITIONS    = 132;
    localparam int          LASS_SCAN_PULSES  = 133;
    localparam int          LASS_RESET_PULSES = 18;
    localparam int          LASS_PIX_W        = 8;
    localparam int          LASS_CNT_W        = 8;

    // ------------------------------------------------------------
    // controller timing, 20 MHz system clock
    // ------------------------------------------------------------
    localparam int          LASS_CLK_HZ       = 20000000;
    localparam int          LASS_SH_SETTLE_NS = 10000;
    localparam int          LASS_SH_CYCLES    = (LASS_SH_SETTLE_NS * (LASS_CLK_HZ / 1000000)
                                                 + 999) / 1000;
    localparam int          LASS_MAX_INT_US   = 2000;
    localparam int          LASS_MAX_INT_CYC  = LASS_MAX_INT_US * (LASS_CLK_HZ / 1000000);
    localparam int          LASS_HALF_PERIOD  = 13;   // 20 MHz / 26 = 769 kHz link clock

    // ------------------------------------------------------------
    // dummy output levels
    // ------------------------------------------------------------
    localparam logic [7:0]  LASS_DUMMY_LEVEL  = 8'h00;

endpackage

//--- lass_link_if.sv
// lass_link_if: link between array sequencer and its scan controller
// assumes: the tb resolves pixel analog out from data and enable
`timescale 1ns/10ps
interface lass_link_if;
    logic       scan_start;     // serial start input
    logic       scan_clk;       // link clock, sampled by the device
    logic [7:0] pixel_analog_out;
    logic       pixel_oe_n;     // low while the device drives the output
    modport dev  (input scan_start, input scan_clk, output pixel_analog_out, output pixel_oe_n);
    modport ctrl (output scan_start, output scan_clk, input pixel_analog_out, input pixel_oe_n);
endinterface

//--- lass_array.sv
// lass_array: device end, shift register sequencer with hold and integrator reset
// assumes: link pins are asynchronous and pass two flops; pixel data comes from user side
`timescale 1ns/10ps
module lass_array
    import lass_pkg::*;
#(
    parameter int NPIX = LASS_PIXELS
) (
    // clock and reset
    input  wire logic                         clk_in,
    input  wire logic                         reset_in,
    // link
    lass_link_if.dev                          link,
    // user side: light levels and state
    input  wire logic [NPIX*LASS_PIX_W-1:0]   light_level_in,
    input  wire logic [LASS_PIX_W-1:0]        dark_level_in,
    output logic                              integ_reset_out,
    output logic                              integrating_out,
    output logic                              hold_strobe_out
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] si_sync_q;
    logic [1:0] ck_sync_q;
    logic       ck_prev_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            si_sync_q <= 2'b00;
            ck_sync_q <= 2'b00;
            ck_prev_q <= 1'b0;
        end else begin
            si_sync_q <= {si_sync_q[0], link.scan_start};
            ck_sync_q <= {ck_sync_q[0], link.scan_clk};
            ck_prev_q <= ck_sync_q[1];
        end
    end

    // edges of the link clock; everything keys off these only
    wire ck_rise = ck_sync_q[1] & ~ck_prev_q;
    wire ck_fall = ~ck_sync_q[1] & ck_prev_q;
    wire start_seen = ck_rise & si_sync_q[1];

    // ------------------------------------------------------------
    // 132-position shift register and rise counter
    // ------------------------------------------------------------
    logic [LASS_POSITIONS-1:0] shift_q;
    logic [LASS_CNT_W-1:0]     pulse_cnt_q;
    logic                      rst_int_q;
    logic [LASS_PIX_W-1:0]     held_q [NPIX];
    logic [LASS_PIX_W-1:0]     held_dark_q;
    logic [LASS_PIX_W-1:0]     out_q;
    logic                      oe_n_q;

    // one-hot token, unset at power up; each start sampled at a rise shifts in a new one
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            shift_q     <= '0;
            pulse_cnt_q <= '0;
        end else if (ck_rise) begin
            shift_q <= {shift_q[LASS_POSITIONS-2:0], si_sync_q[1]};
            if (start_seen)
                pulse_cnt_q <= LASS_CNT_W'(1);
            else if (pulse_cnt_q != 0 && pulse_cnt_q < LASS_CNT_W'(LASS_SCAN_PULSES))
                pulse_cnt_q <= pulse_cnt_q + 1'b1;
            else
                pulse_cnt_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // integrator reset and common hold
    // ------------------------------------------------------------
    wire end_reset = ck_fall && pulse_cnt_q == LASS_CNT_W'(LASS_RESET_PULSES);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            rst_int_q <= 1'b1;
        else if (start_seen)
            rst_int_q <= 1'b1;
        else if (end_reset)
            rst_int_q <= 1'b0;
    end

    // every pixel frozen on the same start edge
    genvar gi;
    generate
        for (gi = 0; gi < NPIX; gi++) begin : g_hold
            always_ff @(posedge clk_in or posedge reset_in) begin
                if (reset_in)
                    held_q[gi] <= '0;
                else if (start_seen)
                    held_q[gi] <= light_level_in[gi*LASS_PIX_W +: LASS_PIX_W];
            end
        end
    endgenerate

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in)
            held_dark_q <= '0;
        else if (start_seen)
            held_dark_q <= dark_level_in;
    end

    // ------------------------------------------------------------
    // output selection by token position
    // ------------------------------------------------------------
    logic [LASS_PIX_W-1:0] sel_val;
    logic                  sel_any;
    always_comb begin
        sel_val = LASS_DUMMY_LEVEL;
        sel_any = |shift_q;
        for (int i = 0; i < NPIX; i++)
            if (shift_q[i + 2])
                sel_val = held_q[i];
        if (shift_q[LASS_POSITIONS-1])
            sel_val = held_dark_q;
    end

    // registered output; token gone means high impedance
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            out_q  <= '0;
            oe_n_q <= 1'b1;
        end else begin
            out_q  <= sel_val;
            oe_n_q <= ~sel_any;
        end
    end

    assign link.pixel_analog_out = out_q;
    assign link.pixel_oe_n       = oe_n_q;
    assign integ_reset_out       = rst_int_q;
    assign integrating_out       = ~rst_int_q;
    assign hold_strobe_out       = start_seen;

endmodule

//--- lass_ctrl.sv
// lass_ctrl: controller end, makes start and link clock, samples pixels
// assumes: device outputs settle well within half a link period
`timescale 1ns/10ps
module lass_ctrl
    import lass_pkg::*;
#(
    parameter int HALF     = LASS_HALF_PERIOD,
    parameter int SETTLE   = LASS_SH_CYCLES,
    parameter int MAX_INT  = LASS_MAX_INT_CYC
) (
    // clock and reset
    input  wire logic                  clk_in,
    input  wire logic                  reset_in,
    // link
    lass_link_if.ctrl                  link,
    // user side
    input  wire logic                  scan_req_in,
    output logic                       sample_valid_out,
    output logic [LASS_CNT_W-1:0]      sample_pos_out,
    output logic [LASS_PIX_W-1:0]      sample_data_out,
    output logic                       scan_valid_out,
    output logic                       busy_out,
    output logic                       int_overrun_out
);

    typedef enum {LASS_IDLE, LASS_START, LASS_RUN, LASS_GAP} lass_state_t;
    lass_state_t state_q;

    // ------------------------------------------------------------
    // link clock divider and phase tracking
    // ------------------------------------------------------------
    logic [15:0]           div_q;
    logic                  ck_q;
    logic                  si_q;
    logic [LASS_CNT_W-1:0] pulse_q;
    logic [15:0]           gap_q;
    logic                  primed_q;
    logic [31:0]           int_q;
    logic                  sv_q;
    logic [LASS_CNT_W-1:0] pos_q;
    logic [LASS_PIX_W-1:0] dat_q;
    logic                  ovr_q;

    wire tick      = div_q == 16'(HALF - 1);
    wire rise_next = tick & ~ck_q;
    wire fall_next = tick & ck_q;
    wire running   = state_q == LASS_START || state_q == LASS_RUN;
    wire go        = state_q == LASS_IDLE && (scan_req_in || !primed_q);

    // one start pulse, 133 pulses, then settle gap
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_q  <= LASS_IDLE;
            div_q    <= '0;
            ck_q     <= 1'b0;
            si_q     <= 1'b0;
            pulse_q  <= '0;
            gap_q    <= '0;
            primed_q <= 1'b0;
        end else begin
            div_q <= (running && !tick) ? div_q + 1'b1 : '0;
            unique case (state_q)
                LASS_IDLE: if (go) begin
                    state_q <= LASS_START;
                    si_q    <= 1'b1;
                    pulse_q <= LASS_CNT_W'(1);  // the start rise is pulse 1
                end
                LASS_START: if (tick) begin
                    ck_q <= ~ck_q;
                    if (fall_next) begin
                        si_q    <= 1'b0;
                        state_q <= LASS_RUN;
                    end
                end
                // count on the rise so pulse_q names the pulse now high
                LASS_RUN: if (tick) begin
                    ck_q <= ~ck_q;
                    if (rise_next)
                        pulse_q <= pulse_q + 1'b1;
                    else if (pulse_q == LASS_CNT_W'(LASS_SCAN_PULSES)) begin
                        state_q <= LASS_GAP;
                        gap_q   <= '0;
                    end
                end
                LASS_GAP: begin
                    gap_q <= gap_q + 1'b1;
                    if (gap_q == 16'(SETTLE - 1)) begin
                        state_q  <= LASS_IDLE;
                        primed_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // sampling, late in the high phase after settling
    // ------------------------------------------------------------
    logic [7:0] ao_s1_q, ao_s2_q;
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ao_s1_q <= '0;
            ao_s2_q <= '0;
        end else begin
            ao_s1_q <= link.pixel_analog_out;
            ao_s2_q <= ao_s1_q;
        end
    end

    wire take = running && fall_next && pulse_q <= LASS_CNT_W'(LASS_POSITIONS);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            sv_q  <= 1'b0;
            pos_q <= '0;
            dat_q <= '0;
        end else begin
            sv_q <= take;
            if (take) begin
                pos_q <= pulse_q;
                dat_q <= ao_s2_q;
            end
        end
    end

    // integration length watchdog; judged once at launch so the start phase cannot clear it
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            int_q <= '0;
            ovr_q <= 1'b0;
        end else if (go) begin
            ovr_q <= int_q > 32'(MAX_INT);
            int_q <= '0;
        end else
            int_q <= (int_q == '1) ? int_q : int_q + 1'b1;
    end

    assign link.scan_start  = si_q;
    assign link.scan_clk    = ck_q;
    assign sample_valid_out = sv_q;
    assign sample_pos_out   = pos_q;
    assign sample_data_out  = dat_q;
    assign scan_valid_out   = primed_q;
    assign busy_out         = state_q != LASS_IDLE;
    assign int_overrun_out  = ovr_q;

endmodule

//--- lass_link_chk.sv
// lass_link_chk: concurrent checks on the start, clock and analog out lines
// assumes: one clk_in domain, reset_in async high; placed beside the link
`timescale 1ns/10ps
module lass_link_chk
    import lass_pkg::*;
#(
    parameter int SETTLE = LASS_SH_CYCLES
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // link lines
    input  wire logic       scan_start,
    input  wire logic       scan_clk,
    input  wire logic [7:0] pixel_analog_out,
    input  wire logic       pixel_oe_n
);
    // ----------------------------------------
    // pulse tracking
    // ----------------------------------------
    logic        clk_d1_q;
    logic [7:0]  pulse_q;
    logic [15:0] idle_q;
    logic        started_q;
    logic        primed_q;
    wire         clk_rise = scan_clk & ~clk_d1_q;
    wire         clk_fall = ~scan_clk & clk_d1_q;
    wire         in_frame = (pulse_q != 8'h00) && (pulse_q <= LASS_POSITIONS);
    wire         dummy_at = (pulse_q == 8'h01) || (pulse_q == 8'h02) || (pulse_q == 8'h83);

    // counters saturate so a stuck link clock still trips a check
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            clk_d1_q  <= 1'b0;
            pulse_q   <= 8'h00;
            idle_q    <= 16'h0000;
            started_q <= 1'b0;
            primed_q  <= 1'b0;
        end else begin
            clk_d1_q  <= scan_clk;
            idle_q    <= clk_fall ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hffff};
            primed_q  <= primed_q | (clk_fall && pulse_q == LASS_SCAN_PULSES);
            if (clk_rise) begin
                pulse_q   <= scan_start ? 8'h01 : pulse_q + {7'h00, pulse_q != 8'hff};
                started_q <= started_q | scan_start;
            end
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    a_start_taken: assert property ($rose(scan_start) |-> ##[1:26] $rose(scan_clk))
        else $error("start not followed by a clock rise");
    a_start_short: assert property ($rose(scan_start) |-> ##[14:38] !scan_start)
        else $error("start still high at the next rise");
    a_clk_half: assert property ($rose(scan_clk) |-> ##13 $fell(scan_clk))
        else $error("link clock high phase wrong");
    a_clk_stops: assert property (clk_rise && pulse_q >= LASS_SCAN_PULSES |-> scan_start)
        else $error("clock pulse beyond the scan");
    a_full_scan: assert property ($rose(scan_start) && started_q |-> pulse_q == LASS_SCAN_PULSES)
        else $error("new start before pulse count complete");
    a_settle_gap: assert property ($rose(scan_start) && started_q |-> idle_q + 1 >= SETTLE)
        else $error("settle gap too short");
    a_drive_frame: assert property (clk_fall && primed_q && in_frame |-> !pixel_oe_n)
        else $error("output not driven in frame");
    a_hiz_after: assert property (clk_fall && pulse_q == LASS_SCAN_PULSES |-> pixel_oe_n)
        else $error("output driven after last value");
    a_dummy_level: assert property (clk_fall && primed_q && dummy_at |->
        pixel_analog_out == LASS_DUMMY_LEVEL)
        else $error("dummy slot level wrong");

    c_new_scan: cover property ($rose(scan_start) && started_q);
    c_primed: cover property ($rose(primed_q));
    c_dark_slot: cover property (clk_fall && pulse_q == LASS_POSITIONS && !pixel_oe_n);
endmodule

//--- linear_array_scan_sequencer_test.sv
// linear_array_scan_sequencer_test: both ends joined over the link, scans checked
// assumes: the controller primes itself after every reset
`timescale 1ns/10ps
module linear_array_scan_sequencer_test;
    import lass_pkg::*;
    // ----------------------------------------
    // signals and ends
    // ----------------------------------------
    logic                              clk_in;
    logic                              reset_in;
    logic                              scan_req;
    logic [LASS_PIXELS*LASS_PIX_W-1:0] light;
    logic [LASS_PIXELS*LASS_PIX_W-1:0] exp_light;
    logic [7:0]                        dark;
    logic [7:0]                        exp_dark;
    logic                              integ_rst;
    logic                              integ_on;
    logic                              hold_pulse;
    logic                              smp_valid;
    logic [LASS_CNT_W-1:0]             smp_pos;
    logic [LASS_PIX_W-1:0]             smp_data;
    logic                              scan_ok;
    logic                              busy;
    logic                              overrun;
    logic [7:0]                        got_d [0:139];
    logic [7:0]                        got_p [0:139];
    int                                n_got;
    int                                err_count;
    int                                checks;

    lass_link_if link ();
    lass_array u_lass_array (.clk_in(clk_in), .reset_in(reset_in), .link(link),
        .light_level_in(light), .dark_level_in(dark), .integ_reset_out(integ_rst),
        .integrating_out(integ_on), .hold_strobe_out(hold_pulse));
    // short settle gap and overrun limit keep the run brief
    lass_ctrl #(.SETTLE(2), .MAX_INT(5000)) u_lass_ctrl (.clk_in(clk_in), .reset_in(reset_in),
        .link(link), .scan_req_in(scan_req), .sample_valid_out(smp_valid),
        .sample_pos_out(smp_pos), .sample_data_out(smp_data), .scan_valid_out(scan_ok),
        .busy_out(busy), .int_overrun_out(overrun));
    lass_link_chk #(.SETTLE(2)) u_lass_link_chk (.clk_in(clk_in), .reset_in(reset_in),
        .scan_start(link.scan_start), .scan_clk(link.scan_clk),
        .pixel_analog_out(link.pixel_analog_out), .pixel_oe_n(link.pixel_oe_n));

    // ----------------------------------------
    // clock and sample capture
    // ----------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // capture off the launch edge so registered outputs have settled
    always @(negedge clk_in) begin
        if (smp_valid === 1'b1 && n_got < 140) begin
            got_d[n_got] = smp_data;
            got_p[n_got] = smp_pos;
            n_got++;
        end
    end

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        checks++;
        if (seen !== want) begin
            err_count++;
            $display("ERROR %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic give_up();
        err_count++;
        complete_run();
    endtask

    // slot order: two dummies, pixels in array order, dummy, dark level
    function automatic logic [7:0] exp_val(input int p);
        if (p == 132) return exp_dark;
        if (p < 3 || p == 131) return LASS_DUMMY_LEVEL;
        return exp_light[(p - 3) * 8 +: 8];
    endfunction

    task automatic wait_idle();
        int k;
        for (k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk_in);
        if (busy !== 1'b0) give_up();
        repeat (4) @(negedge clk_in);
    endtask

    task automatic prime();
        repeat (2) @(negedge clk_in);
        check(scan_ok, 1'b0);
        check(busy, 1'b1);
        wait_idle();
        check(scan_ok, 1'b1);
        $display("priming done");
    endtask

    task automatic run_scan(input int gap, input logic exp_ovr);
        int k;
        int d;
        int want_d = (2 * LASS_RESET_PULSES - 1) * LASS_HALF_PERIOD;
        repeat (gap) @(negedge clk_in);
        for (k = 0; k < 32; k++) light[k*32 +: 32] = $urandom;
        dark      = 8'($urandom);
        exp_light = light;
        exp_dark  = dark;
        n_got     = 0;
        scan_req  = 1'b1;
        for (k = 0; k < 9000 && hold_pulse !== 1'b1; k++) @(negedge clk_in);
        if (hold_pulse !== 1'b1) give_up();
        scan_req = 1'b0;
        @(negedge clk_in); // values freeze at the edge that ends the strobe
        light    = ~light; // a late change must not reach the held values
        check(integ_rst, 1'b1);
        for (d = 0; d < 1000 && integ_rst === 1'b1; d++) @(negedge clk_in);
        check(d, want_d);
        check(integ_on, 1'b1);
        wait_idle();
        check(n_got, LASS_POSITIONS);
        for (k = 0; k < 132; k++) begin
            check(got_p[k], k + 1);
            check(got_d[k], exp_val(k + 1));
        end
        check(overrun, exp_ovr);
        check(link.pixel_oe_n, 1'b1);
        $display("scan done, gap %0d", gap);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_in  = 1'b1;
        scan_req  = 1'b0;
        light     = '0;
        dark      = 8'h00;
        n_got     = 0;
        err_count = 0;
        checks    = 0;
        void'($urandom(32'h7d8f));
        repeat (3) @(negedge clk_in);
        reset_in = 1'b0;
        prime();
        run_scan(0, 1'b0);
        run_scan(6000, 1'b1);
        run_scan(0, 1'b0);
        repeat (2) run_scan($urandom_range(900, 0), 1'b0);
        // reset in mid-scan must drop the output and demand a new priming scan
        scan_req = 1'b1;
        repeat (600) @(negedge clk_in);
        reset_in = 1'b1;
        scan_req = 1'b0;
        @(negedge clk_in);
        check(link.pixel_oe_n, 1'b1);
        check(scan_ok, 1'b0);
        reset_in = 1'b0;
        $display("mid-scan reset done");
        prime();
        run_scan(0, 1'b0);
        complete_run();
    end
endmodule
